// >>> crau_params.svh
/*
 * Constants for the control register access unit: instruction field
 * positions, operation codes and register space size.
 * Assumes it is included by the package before any type is declared.
 */
`ifndef CRAU_PARAMS_SVH
`define CRAU_PARAMS_SVH

// ----------------------------------------------------------------------
// Widths and space
// ----------------------------------------------------------------------
`define CRAU_INT_W 32
`define CRAU_SPACE_SIZE 4096
`define CRAU_ADDR_W 12
`define CRAU_IDX_W 5

// ----------------------------------------------------------------------
// Instruction fields
// ----------------------------------------------------------------------
`define CRAU_SPEC_HI 31
`define CRAU_SPEC_LO 20
`define CRAU_SRC_HI 19
`define CRAU_SRC_LO 15
`define CRAU_MINOR_HI 14
`define CRAU_MINOR_LO 12
`define CRAU_DEST_HI 11
`define CRAU_DEST_LO 7
`define CRAU_OPC_HI 6
`define CRAU_OPC_LO 0
`define CRAU_OPC_SYSTEM 7'h73

// ----------------------------------------------------------------------
// Minor operation codes
// ----------------------------------------------------------------------
`define CRAU_OP_SWAP 3'h1
`define CRAU_OP_SET 3'h2
`define CRAU_OP_CLEAR 3'h3
`define CRAU_OP_SWAP_IMM 3'h5
`define CRAU_OP_SET_IMM 3'h6
`define CRAU_OP_CLEAR_IMM 3'h7
`define CRAU_IMM_BIT 2

`endif

// >>> crau_pkg.sv
/*
 * Types for the control register access unit.
 * Assumes crau_params.svh is on the include path.
 */
`include "crau_params.svh"

package crau_pkg;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {CRAU_IDLE, CRAU_EVAL, CRAU_DONE} crau_fsm_type;

    typedef struct packed {
        logic valid;
        logic [31:0] instr;
        logic [`CRAU_INT_W-1:0] src_value;
    } crau_req_type;

    typedef struct packed {
        logic valid;
        logic illegal;
        logic dest_we;
        logic [`CRAU_IDX_W-1:0] dest_index;
        logic [`CRAU_INT_W-1:0] dest_value;
    } crau_resp_type;

    typedef struct packed {
        logic [`CRAU_ADDR_W-1:0] addr;
        logic read_strobe;
        logic write_strobe;
        logic suppress_implicit;
        logic [`CRAU_INT_W-1:0] wdata;
        logic [`CRAU_INT_W-1:0] field_mask;
    } crau_bank_out_type;

    typedef struct packed {
        logic exists;
        logic read_only;
        logic custom;
        logic [`CRAU_INT_W-1:0] rdata;
        logic [`CRAU_INT_W-1:0] writable;
    } crau_bank_in_type;

    typedef struct packed {
        crau_fsm_type fsm;
        logic [2:0] minor;
        logic bad_opcode;
        logic [`CRAU_IDX_W-1:0] src_index;
        logic [`CRAU_IDX_W-1:0] dest_index;
        logic [`CRAU_INT_W-1:0] operand;
        crau_bank_out_type bank;
        crau_resp_type resp;
    } crau_state_type;

endpackage

// >>> crau_unit.sv
/*
 * Execution unit for the six atomic control register access operations.
 * It takes an undecoded instruction word and source value from the pipeline,
 * reads the addressed register, merges the operand and writes it back,
 * answering in the same cycle as the write strobe with the old value for the destination register.
 * Assumes a register bank on the same clock that presents the addressed
 * register's data and attributes combinationally from its address, and
 * that acts on side effects only when the strobes are high.
 */
`include "crau_params.svh"

module crau_unit
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire crau_pkg::crau_req_type req,
    output logic req_ready,
    output crau_pkg::crau_resp_type resp,
    output crau_pkg::crau_bank_out_type bank_out,
    input wire crau_pkg::crau_bank_in_type bank_in
);
    import crau_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    crau_state_type state;
    crau_state_type next_state;

    logic [2:0] req_minor;
    logic [6:0] req_opcode;
    logic [`CRAU_IDX_W-1:0] req_src_index;
    logic is_swap;
    logic is_set;
    logic is_clear;
    logic is_imm;
    logic op_known;
    logic do_read;
    logic do_write;
    logic fault;
    logic [`CRAU_INT_W-1:0] old_value;
    logic [`CRAU_INT_W-1:0] raw_value;
    logic [`CRAU_INT_W-1:0] merged_value;

    // ------------------------------------------------------------------
    // Field extraction of the incoming instruction
    // ------------------------------------------------------------------
    assign req_minor = req.instr[`CRAU_MINOR_HI:`CRAU_MINOR_LO];
    assign req_opcode = req.instr[`CRAU_OPC_HI:`CRAU_OPC_LO];
    assign req_src_index = req.instr[`CRAU_SRC_HI:`CRAU_SRC_LO];

    // A new request is only taken when the previous one has fully retired,
    // so its side effects are visible before the next access starts.
    assign req_ready = (state.fsm == CRAU_IDLE);

    // ------------------------------------------------------------------
    // Operation decode of the held instruction
    // ------------------------------------------------------------------
    always_comb
    begin
        is_swap = 1'b0;
        is_set = 1'b0;
        is_clear = 1'b0;
        op_known = 1'b1;
        case (state.minor)
            `CRAU_OP_SWAP, `CRAU_OP_SWAP_IMM:
            begin
                is_swap = 1'b1;
            end
            `CRAU_OP_SET, `CRAU_OP_SET_IMM:
            begin
                is_set = 1'b1;
            end
            `CRAU_OP_CLEAR, `CRAU_OP_CLEAR_IMM:
            begin
                is_clear = 1'b1;
            end
            default:
            begin
                op_known = 1'b0;
            end
        endcase
        is_imm = state.minor[`CRAU_IMM_BIT];
    end

    // ------------------------------------------------------------------
    // Read and write decisions
    // ------------------------------------------------------------------
    always_comb
    begin
        // Swap reads only when a destination will receive the value.
        if (is_swap)
        begin
            do_read = (state.dest_index != '0);
        end
        else
        begin
            do_read = 1'b1;
        end
        // Set and clear write only when the source index or the immediate
        // is nonzero; for the register form the index decides, not the value.
        if (is_swap)
        begin
            do_write = 1'b1;
        end
        else
        begin
            do_write = (state.src_index != '0);
        end
        // Absent registers always fault; read-only only when written.
        fault = state.bad_opcode || !op_known || !bank_in.exists ||
            (do_write && bank_in.read_only);
    end

    // ------------------------------------------------------------------
    // Value merge
    // ------------------------------------------------------------------
    always_comb
    begin
        // The bank shows the value as held before this instruction, so an
        // automatic update caused by this same instruction is never seen.
        old_value = bank_in.rdata;
        if (is_swap)
        begin
            raw_value = state.operand;
        end
        else if (is_set)
        begin
            raw_value = old_value | state.operand;
        end
        else if (is_clear)
        begin
            raw_value = old_value & ~state.operand;
        end
        else
        begin
            raw_value = old_value;
        end
        // Bits the register does not let software change keep their value.
        merged_value = (old_value & ~bank_in.writable) | (raw_value & bank_in.writable);
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_state.bank.read_strobe = 1'b0;
        next_state.bank.write_strobe = 1'b0;
        next_state.bank.suppress_implicit = 1'b0;
        next_state.resp.valid = 1'b0;
        case (state.fsm)
            CRAU_IDLE:
            begin
                if (req.valid)
                begin
                    next_state.fsm = CRAU_EVAL;
                    next_state.minor = req_minor;
                    next_state.bad_opcode = (req_opcode != `CRAU_OPC_SYSTEM);
                    next_state.bank.addr = req.instr[`CRAU_SPEC_HI:`CRAU_SPEC_LO];
                    next_state.src_index = req_src_index;
                    next_state.dest_index = req.instr[`CRAU_DEST_HI:`CRAU_DEST_LO];
                    if (req_minor[`CRAU_IMM_BIT])
                    begin
                        next_state.operand = {{(`CRAU_INT_W-`CRAU_IDX_W){1'b0}}, req_src_index};
                    end
                    else
                    begin
                        next_state.operand = req.src_value;
                    end
                end
            end
            CRAU_EVAL:
            begin
                // Read and write side effects fire together in one cycle, so
                // the access stays indivisible against anything else.
                next_state.fsm = CRAU_DONE;
                next_state.bank.read_strobe = do_read && !fault && bank_in.custom;
                next_state.bank.write_strobe = do_write && !fault;
                next_state.bank.suppress_implicit = do_write && !fault;
                next_state.bank.wdata = merged_value;
                if (is_swap)
                begin
                    next_state.bank.field_mask = '1;
                end
                else
                begin
                    next_state.bank.field_mask = state.operand;
                end
                next_state.resp.valid = 1'b1;
                next_state.resp.illegal = fault;
                next_state.resp.dest_index = state.dest_index;
                next_state.resp.dest_we = do_read && !fault && (state.dest_index != '0);
                if (do_read && !fault)
                begin
                    next_state.resp.dest_value = old_value;
                end
                else
                begin
                    next_state.resp.dest_value = '0;
                end
            end
            CRAU_DONE:
            begin
                next_state.fsm = CRAU_IDLE;
            end
            default:
            begin
                next_state.fsm = CRAU_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign resp = state.resp;
    assign bank_out = state.bank;

endmodule

// >>> crau_props.sv
/*
 * Checker for the control register access unit ports.
 * Assumes it is bound to crau_unit and that answers come two edges after a take.
 */
module crau_props
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire crau_pkg::crau_req_type req,
    input wire logic req_ready,
    input wire crau_pkg::crau_resp_type resp,
    input wire crau_pkg::crau_bank_out_type bank_out,
    input wire crau_pkg::crau_bank_in_type bank_in
);
    import crau_pkg::*;
    logic [63:0] h1;
    logic [63:0] h2;
    logic [31:0] ins;
    logic [31:0] srcv;
    // The taken word is two edges old when its answer shows.
    always_ff @(posedge clk_sys)
    begin
        h1 <= {req.src_value, req.instr};
        h2 <= h1;
    end
    assign ins = h2[31:0];
    assign srcv = h2[63:32];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence s_take;
        req.valid && req_ready;
    endsequence
    sequence s_answer;
        !req_ready ##1 (resp.valid && !req_ready);
    endsequence
    chk_answer_time: assert property (s_take |=> s_answer)
        else $error("answer not two cycles after take");
    chk_resp_pulse: assert property (resp.valid |=> !resp.valid [*2])
        else $error("answer longer than one cycle");
    chk_strobe_owner: assert property ((bank_out.write_strobe || bank_out.read_strobe) |-> resp.valid)
        else $error("strobe outside answer cycle");
    chk_fault_quiet: assert property (resp.valid && resp.illegal |->
        !bank_out.write_strobe && !bank_out.read_strobe && !resp.dest_we) else $error("fault with strobe");
    chk_implicit_drop: assert property (bank_out.write_strobe == bank_out.suppress_implicit)
        else $error("implicit update not dropped");
    chk_read_custom: assert property (bank_out.read_strobe |-> bank_in.custom)
        else $error("read effect on standard register");
    chk_swap_noread: assert property (resp.valid && ins[13:12] == 2'b01 && ins[11:7] == 5'h00
        |-> !bank_out.read_strobe) else $error("swap to zero register read");
    chk_setclr_zero: assert property (resp.valid && ins[13] && ins[19:15] == 5'h00
        |-> !bank_out.write_strobe) else $error("set or clear with zero source wrote");
    chk_setclr_read: assert property (resp.valid && !resp.illegal && ins[13] && bank_in.custom
        |-> bank_out.read_strobe) else $error("set or clear skipped read");
    chk_swap_write: assert property (resp.valid && !resp.illegal && ins[13:12] == 2'b01
        |-> bank_out.write_strobe && bank_out.field_mask == 32'hffff_ffff) else $error("swap write wrong");
    chk_mask_value: assert property (bank_out.write_strobe && ins[13] |-> bank_out.field_mask ==
        (ins[14] ? {27'h000_0000, ins[19:15]} : srcv)) else $error("field mask wrong");
    chk_old_value: assert property (resp.valid && resp.dest_we |-> resp.dest_value == $past(bank_in.rdata))
        else $error("returned value not the old one");
endmodule
bind crau_unit crau_props u_props (.clk_sys(clk_sys), .srst(srst), .req(req), .req_ready(req_ready),
    .resp(resp), .bank_out(bank_out), .bank_in(bank_in));

// >>> crau_bank_model.sv
/*
 * Behavioural register bank facing the access unit.
 * Assumes the unit's clock; it writes whatever is strobed, read-only or not.
 */
module crau_bank_model
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire crau_pkg::crau_bank_out_type bank_out,
    output crau_pkg::crau_bank_in_type bank_in
);
    import crau_pkg::*;
    logic [31:0] store [16];
    int reads;
    always_comb
    begin
        bank_in.exists = bank_out.addr[11:4] == 8'h00;
        bank_in.read_only = bank_out.addr[3];
        bank_in.custom = bank_out.addr[2];
        bank_in.writable = bank_out.addr[1] ? 32'h0000_00ff : 32'hffff_ffff;
        // Absent places show the inverse of the stored entry at the low four address bits.
        bank_in.rdata = bank_in.exists ? store[bank_out.addr[3:0]] : ~store[bank_out.addr[3:0]];
    end
    always @(posedge clk_sys)
    begin
        if (srst)
        begin
            for (int i = 0; i < 16; i++)
                store[i] <= 32'(i) * 32'h0101_0101;
            reads <= 0;
        end
        else
        begin
            if (bank_out.write_strobe)
                store[bank_out.addr[3:0]] <= bank_out.wdata;
            if (bank_out.read_strobe)
                reads <= reads + 1;
        end
    end
endmodule

// >>> crau_tb.sv
/*
 * Self-checking bench for crau_unit with a behavioural bank.
 * Assumes the two-cycle answer and one request per four cycles.
 */
`include "crau_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import crau_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    crau_req_type req = '0;
    logic req_ready;
    crau_resp_type resp;
    crau_bank_out_type bank_out;
    crau_bank_in_type bank_in;
    logic [38:0] expq [$];
    logic [31:0] shadow [16];
    logic [31:0] seed = 32'h01ad_4f42;
    logic [2:0] minors [6] = '{`CRAU_OP_SWAP, `CRAU_OP_SET, `CRAU_OP_CLEAR, `CRAU_OP_SWAP_IMM,
        `CRAU_OP_SET_IMM, `CRAU_OP_CLEAR_IMM};
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    int exp_reads = 0;
    always #20 clk_sys = ~clk_sys;
    crau_unit DUT (.clk_sys(clk_sys), .srst(srst), .req(req), .req_ready(req_ready), .resp(resp),
        .bank_out(bank_out), .bank_in(bank_in));
    crau_bank_model u_bank (.clk_sys(clk_sys), .srst(srst), .bank_out(bank_out), .bank_in(bank_in));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task check(input string name, input logic [38:0] seen, input logic [38:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task close_out();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // --------
    // Request driver and expectation
    // --------
    task issue(input logic [2:0] mn, input logic [11:0] csr, input logic [4:0] idx, input logic [4:0] rd,
        input logic [31:0] sv, input logic [6:0] opc);
        logic [31:0] opnd, old, wm, nv;
        logic sw, rdo, wr, ill;
        opnd = mn[2] ? {27'h000_0000, idx} : sv;
        sw = mn[1:0] == 2'b01;
        rdo = !sw || rd != 5'h00;
        wr = sw || idx != 5'h00;
        ill = opc != `CRAU_OPC_SYSTEM || mn[1:0] == 2'b00 || csr[11:4] != 8'h00 || (wr && csr[3]);
        old = shadow[csr[3:0]];
        wm = csr[1] ? 32'h0000_00ff : 32'hffff_ffff;
        nv = sw ? opnd : (mn[0] ? old & ~opnd : old | opnd);
        if (!ill && wr)
            shadow[csr[3:0]] = (nv & wm) | (old & ~wm);
        if (!ill && rdo && csr[2])
            exp_reads++;
        expq.push_back({ill, !ill && rd != 5'h00, rd, (!ill && rdo) ? old : 32'h0000_0000});
        @(negedge clk_sys);
        req.valid = 1'b1;
        req.instr = {csr, idx, mn, rd, opc};
        req.src_value = sv;
        do @(posedge clk_sys); while (req_ready !== 1'b1);
        @(negedge clk_sys);
        req.valid = 1'b0;
        req.instr = rnd();
        req.src_value = rnd();
        repeat (2) @(negedge clk_sys);
    endtask
    always @(posedge clk_sys)
    begin
        if (!srst && resp.valid === 1'b1)
        begin
            if (expq.size() == 0)
                check("spare response", {resp.illegal, resp.dest_we, resp.dest_index, resp.dest_value},
                    39'h7f_ffff_ffff);
            else
                check("response", {resp.illegal, resp.dest_we, resp.dest_index, resp.dest_value},
                    expq.pop_front());
        end
    end
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            mismatches++;
            close_out();
        end
    end
    initial
    begin
        logic [31:0] r;
        for (int i = 0; i < 16; i++)
            shadow[i] = 32'(i) * 32'h0101_0101;
        repeat (16) @(negedge clk_sys);
        srst = 1'b0;
        // Zero value comes up a quarter of the time; together with a nonzero index, about three sixteenths.
        for (int n = 0; n < 300; n++)
        begin
            r = rnd();
            issue(minors[n % 6], {7'h00, r[20], r[3:0]}, r[9:8] == 2'b00 ? 5'h00 : r[14:10],
                r[7:6] == 2'b00 ? 5'h00 : r[19:15], r[23:22] == 2'b00 ? 32'h0000_0000 : rnd(), `CRAU_OPC_SYSTEM);
        end
        $display("test random sweep done");
        issue(`CRAU_OP_SWAP, 12'h005, 5'h03, 5'h01, 32'h1234_5678, 7'h33);
        issue(3'h0, 12'h001, 5'h02, 5'h04, 32'h0000_00ff, `CRAU_OPC_SYSTEM);
        issue(3'h4, 12'h006, 5'h07, 5'h02, 32'h0000_0001, `CRAU_OPC_SYSTEM);
        $display("test bad decode done");
        for (int i = 0; i < 16; i++)
            check("register", {7'h00, u_bank.store[i]}, {7'h00, shadow[i]});
        check("read effects", 39'(u_bank.reads), 39'(exp_reads));
        check("pending", 39'(expq.size()), 39'h00_0000_0000);
        close_out();
    end
endmodule
